// >>> include/lane0_consts.vh
// Purpose: offsets, field positions, reset values and codes of the lane 0
//          conditioning registers
// Assumes: byte-wide registers reached over the register port at byte offsets
// Notes:   definitions only
`ifndef LANE0_CONSTS_VH
`define LANE0_CONSTS_VH

`define OFF_INPUT_BOOST      8'h2c
`define OFF_OUTA_SWING       8'h2d
`define OFF_OUTA_EMPHASIS    8'h2e
`define OFF_SQUELCH_LEVEL    8'h2f
`define OFF_OUTB_IDLE_SPEED  8'h32
`define OFF_OUTB_SWING       8'h34

`define RST_INPUT_BOOST      8'h20
`define RST_OUTA_SWING       8'h03
`define RST_OUTA_EMPHASIS    8'h03
`define RST_SQUELCH_LEVEL    8'h00
`define RST_OUTB_IDLE_SPEED  8'h00
`define RST_OUTB_SWING       8'h03

// writable bits; the rest are reserved and read as zero
`define MASK_INPUT_BOOST     8'h3f
`define MASK_SWING           8'h7f
`define MASK_EMPHASIS        8'hff
`define MASK_SQUELCH         8'h0f
`define MASK_IDLE_SPEED      8'h33

// boost field positions
`define BOOST_EN_BIT         5
`define BOOST_STAGE_HI       4
`define BOOST_STAGE_LO       3
`define BOOST_STEP_HI        2
`define BOOST_STEP_LO        0

// boost codes, index 0 is bypass
`define BOOST_BYPASS         6'h20
`define BOOST_5DB0           6'h2a
`define BOOST_9DB0           6'h30
`define BOOST_11DB7          6'h32
`define BOOST_14DB6          6'h39
`define BOOST_18DB4          6'h35
`define BOOST_20DB0          6'h37
`define BOOST_21DB2          6'h3b
`define BOOST_28DB4          6'h3d

// swing codes
`define SWING_600MV          7'h03
`define SWING_800MV          7'h07
`define SWING_1000MV         7'h0f
`define SWING_1200MV         7'h1f
`define SWING_RESERVED       7'h3f

// emphasis field and codes
`define EMPH_TYPE_BIT        7
`define EMPH_0DB0            8'h01
`define EMPH_3DB5            8'he8
`define EMPH_6DB0            8'h88
`define EMPH_9DB0            8'h90
`define EMPH_12DB0           8'ha0

// squelch fields
`define SQ_DEASSERT_HI       3
`define SQ_DEASSERT_LO       2
`define SQ_ASSERT_HI         1
`define SQ_ASSERT_LO         0

// idle / speed bits
`define IDLE_AUTO_BIT        5
`define IDLE_MUTE_BIT        4
`define RATE_AUTO_BIT        1
`define RATE_FAST_BIT        0

`endif

// >>> rtl/lane0_reg_byte.v
// Purpose: one byte-wide configuration register with reserved-bit masking
// Assumes: write strobe is a single-cycle pulse synchronous to clk_sys_in
// Notes:   reserved bits are not stored and read as zero
`timescale 1ns/1ps
`default_nettype none
module lane0_reg_byte #(
  parameter [7:0] RESET_VALUE = 8'h00,
  parameter [7:0] WRITE_MASK  = 8'hff
) (
  // clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_in,
  // write side
  input  wire       wr_en_in,
  input  wire [7:0] wr_data_in,
  // stored value
  output reg  [7:0] value_out
);

  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= RESET_VALUE & WRITE_MASK;
    end else if (wr_en_in) begin
      value_out <= wr_data_in & WRITE_MASK;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/lane0_conditioning_regs.v
// Purpose: lane 0 conditioning register bank and analog control decode
// Assumes: the serial host engine delivers byte reads and writes on the
//          register port, one-cycle strobes, synchronous to clk_sys_in
// Notes:   every decoded control output is registered
//          an unknown code raises its bad flag; the boost level and emphasis cut fields
//          show the all-ones sentinel, the swing level field shows 0
//          a read and a write in one cycle: the read returns the old value
//          reset values of the controls are decoded from the register
//          reset images, so the two can never disagree
//
// Contract
// - boost field: bit 5 enable, bits 4:3 gain stage, bits 2:0 step.
// - boost code 20h means equalizer bypass and is the reset value.
// - boost codes 2Ah, 30h, 32h give about 5, 9, 11.7 dB.
// - boost codes 39h, 35h, 37h give about 14.6, 18.4, 20 dB.
// - boost codes 3Bh, 3Dh give about 21.2, 28.4 dB, the strongest.
// - swing 03h/07h/0Fh/1Fh give 600/800/1000/1200 mV; 3Fh reserved.
// - emphasis bit 7 selects compatibility or enhanced; bits 6:0 level.
// - emphasis 01h gives 0.0 dB, E8h gives -3.5 dB.
// - emphasis 88h, 90h, A0h give -6, -9, -12 dB.
// - squelch bits 3:2 de-assert level, bits 1:0 assert level.
// - squelch code 00 gives 110 mV de-assert, 70 mV assert.
// - codes 01, 10, 11 give 150/110, 170/130, 190/150 mV.
// - output B bit 5 automatic idle; else bit 4 sets muting.
// - manual idle bit 4: 0 keeps output on, 1 mutes it.
// - output B bit 1 automatic rate; else bit 0 chooses rate.
// - manual rate bit 0: 0 is 2.5-3.2 Gbps, 1 is 5.0-6.4 Gbps.
`timescale 1ns/1ps
`default_nettype none
`include "lane0_consts.vh"
module lane0_conditioning_regs (
  // clock and reset
  input  wire       clk_sys_in,
  input  wire       rst_in,
  // register port from the serial host engine
  input  wire [7:0] reg_addr_in,
  input  wire       reg_wr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  output reg        reg_addr_err_out,
  // input lane 0 equalizer
  output reg        rx_boost_enable_out,
  output reg  [1:0] gain_stage_field_out,
  output reg  [2:0] boost_step_field_out,
  output reg  [3:0] rx_boost_level_out,
  output reg        rx_boost_code_bad_out,
  // output A driver
  output reg  [6:0] output_a_swing_code_out,
  output reg  [1:0] output_a_swing_level_out,
  output reg        output_a_swing_bad_out,
  output reg        output_a_emphasis_enhanced_out,
  output reg  [6:0] output_a_emphasis_level_out,
  output reg  [2:0] output_a_tx_emphasis_cut_out,
  output reg        output_a_emphasis_bad_out,
  // input lane 0 idle detector
  output reg  [1:0] squelch_deassert_sel_out,
  output reg  [1:0] squelch_assert_sel_out,
  // output B idle and rate
  output reg        output_b_idle_auto_out,
  output reg        output_b_mute_out,
  output reg        output_b_signal_presence_detector_en_out,
  output reg        output_b_rate_auto_out,
  output reg        output_b_rate_fast_out,
  // output B driver
  output reg  [6:0] output_b_swing_code_out,
  output reg  [1:0] output_b_swing_level_out,
  output reg        output_b_swing_bad_out
);

  wire [7:0] boost_q;
  wire [7:0] outa_swing_q;
  wire [7:0] outa_emph_q;
  wire [7:0] squelch_q;
  wire [7:0] idle_speed_q;
  wire [7:0] outb_swing_q;

  wire hit_boost   = (reg_addr_in == `OFF_INPUT_BOOST);
  wire hit_aswing  = (reg_addr_in == `OFF_OUTA_SWING);
  wire hit_aemph   = (reg_addr_in == `OFF_OUTA_EMPHASIS);
  wire hit_squelch = (reg_addr_in == `OFF_SQUELCH_LEVEL);
  wire hit_idle    = (reg_addr_in == `OFF_OUTB_IDLE_SPEED);
  wire hit_bswing  = (reg_addr_in == `OFF_OUTB_SWING);
  wire hit_any     = hit_boost | hit_aswing | hit_aemph | hit_squelch |
                     hit_idle | hit_bswing;

  // swing code to level 0..3 (600..1200 mV), flag for any other code
  function [2:0] swing_decode;
    input [6:0] code;
    begin
      case (code)
        `SWING_600MV:  swing_decode = 3'h0;
        `SWING_800MV:  swing_decode = 3'h1;
        `SWING_1000MV: swing_decode = 3'h2;
        `SWING_1200MV: swing_decode = 3'h3;
        default:       swing_decode = 3'h4;
      endcase
    end
  endfunction

  // storage, reserved bits masked off at write
  lane0_reg_byte #(.RESET_VALUE(`RST_INPUT_BOOST),
                   .WRITE_MASK(`MASK_INPUT_BOOST)) u_boost (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (reg_wr_in & hit_boost),
    .wr_data_in (reg_wdata_in),
    .value_out  (boost_q)
  );
  lane0_reg_byte #(.RESET_VALUE(`RST_OUTA_SWING),
                   .WRITE_MASK(`MASK_SWING)) u_aswing (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (reg_wr_in & hit_aswing),
    .wr_data_in (reg_wdata_in),
    .value_out  (outa_swing_q)
  );
  lane0_reg_byte #(.RESET_VALUE(`RST_OUTA_EMPHASIS),
                   .WRITE_MASK(`MASK_EMPHASIS)) u_aemph (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (reg_wr_in & hit_aemph),
    .wr_data_in (reg_wdata_in),
    .value_out  (outa_emph_q)
  );
  lane0_reg_byte #(.RESET_VALUE(`RST_SQUELCH_LEVEL),
                   .WRITE_MASK(`MASK_SQUELCH)) u_squelch (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (reg_wr_in & hit_squelch),
    .wr_data_in (reg_wdata_in),
    .value_out  (squelch_q)
  );
  lane0_reg_byte #(.RESET_VALUE(`RST_OUTB_IDLE_SPEED),
                   .WRITE_MASK(`MASK_IDLE_SPEED)) u_idle (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (reg_wr_in & hit_idle),
    .wr_data_in (reg_wdata_in),
    .value_out  (idle_speed_q)
  );
  lane0_reg_byte #(.RESET_VALUE(`RST_OUTB_SWING),
                   .WRITE_MASK(`MASK_SWING)) u_bswing (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (reg_wr_in & hit_bswing),
    .wr_data_in (reg_wdata_in),
    .value_out  (outb_swing_q)
  );

  // read mux; unmapped offsets read as zero
  reg [7:0] rdata_d;
  always @* begin
    case (reg_addr_in)
      `OFF_INPUT_BOOST:     rdata_d = boost_q;
      `OFF_OUTA_SWING:      rdata_d = outa_swing_q;
      `OFF_OUTA_EMPHASIS:   rdata_d = outa_emph_q;
      `OFF_SQUELCH_LEVEL:   rdata_d = squelch_q;
      `OFF_OUTB_IDLE_SPEED: rdata_d = idle_speed_q;
      `OFF_OUTB_SWING:      rdata_d = outb_swing_q;
      default:              rdata_d = 8'h00;
    endcase
  end

  // read data holds until the next read; a write never disturbs it
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out    <= 8'h00;
      reg_rvalid_out   <= 1'b0;
      reg_addr_err_out <= 1'b0;
    end else begin
      reg_rvalid_out   <= reg_rd_in;
      reg_addr_err_out <= (reg_rd_in | reg_wr_in) & ~hit_any;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

  // boost code to level: 0 bypass, 1..8 rising boost, 4'hf other codes
  function [3:0] boost_decode;
    input [5:0] code;
    begin
      case (code)
        `BOOST_BYPASS: boost_decode = 4'h0;
        `BOOST_5DB0:   boost_decode = 4'h1;
        `BOOST_9DB0:   boost_decode = 4'h2;
        `BOOST_11DB7:  boost_decode = 4'h3;
        `BOOST_14DB6:  boost_decode = 4'h4;
        `BOOST_18DB4:  boost_decode = 4'h5;
        `BOOST_20DB0:  boost_decode = 4'h6;
        `BOOST_21DB2:  boost_decode = 4'h7;
        `BOOST_28DB4:  boost_decode = 4'h8;
        default:       boost_decode = 4'hf;
      endcase
    end
  endfunction

  // emphasis code to cut: 0 for 0 dB up to 4 for -12 dB, 3'h7 other codes
  function [2:0] emph_decode;
    input [7:0] code;
    begin
      case (code)
        `EMPH_0DB0:  emph_decode = 3'h0;
        `EMPH_3DB5:  emph_decode = 3'h1;
        `EMPH_6DB0:  emph_decode = 3'h2;
        `EMPH_9DB0:  emph_decode = 3'h3;
        `EMPH_12DB0: emph_decode = 3'h4;
        default:     emph_decode = 3'h7;
      endcase
    end
  endfunction

  // register images while reset is held
  // masked like a write, so reserved bits stay zero here as well
  localparam [7:0] BOOST_RST   = `RST_INPUT_BOOST & `MASK_INPUT_BOOST;
  localparam [7:0] ASWING_RST  = `RST_OUTA_SWING & `MASK_SWING;
  localparam [7:0] AEMPH_RST   = `RST_OUTA_EMPHASIS & `MASK_EMPHASIS;
  localparam [7:0] SQUELCH_RST = `RST_SQUELCH_LEVEL & `MASK_SQUELCH;
  localparam [7:0] IDLE_RST    = `RST_OUTB_IDLE_SPEED & `MASK_IDLE_SPEED;
  localparam [7:0] BSWING_RST  = `RST_OUTB_SWING & `MASK_SWING;
  // decodes of those images, shown on the controls during reset
  localparam [3:0] BOOST_LVL_RST  = boost_decode(BOOST_RST[5:0]);
  localparam [2:0] EMPH_CUT_RST   = emph_decode(AEMPH_RST);
  localparam [2:0] ASWING_DEC_RST = swing_decode(ASWING_RST[6:0]);
  localparam [2:0] BSWING_DEC_RST = swing_decode(BSWING_RST[6:0]);

  wire [3:0] boost_level_d = boost_decode(boost_q[5:0]);
  wire [2:0] emph_cut_d    = emph_decode(outa_emph_q);
  wire [2:0] aswing_dec    = swing_decode(outa_swing_q[6:0]);
  wire [2:0] bswing_dec    = swing_decode(outb_swing_q[6:0]);

  // registered analog controls, refreshed the cycle after each write
  always @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_boost_enable_out            <= BOOST_RST[`BOOST_EN_BIT];
      gain_stage_field_out           <=
        BOOST_RST[`BOOST_STAGE_HI:`BOOST_STAGE_LO];
      boost_step_field_out           <=
        BOOST_RST[`BOOST_STEP_HI:`BOOST_STEP_LO];
      rx_boost_level_out             <= BOOST_LVL_RST;
      rx_boost_code_bad_out          <= (BOOST_LVL_RST == 4'hf);
      output_a_swing_code_out        <= ASWING_RST[6:0];
      output_a_swing_level_out       <= ASWING_DEC_RST[1:0];
      output_a_swing_bad_out         <= ASWING_DEC_RST[2];
      output_a_emphasis_enhanced_out <= AEMPH_RST[`EMPH_TYPE_BIT];
      output_a_emphasis_level_out    <= AEMPH_RST[6:0];
      output_a_tx_emphasis_cut_out   <= EMPH_CUT_RST;
      output_a_emphasis_bad_out      <= (EMPH_CUT_RST == 3'h7);
      squelch_deassert_sel_out       <=
        SQUELCH_RST[`SQ_DEASSERT_HI:`SQ_DEASSERT_LO];
      squelch_assert_sel_out         <=
        SQUELCH_RST[`SQ_ASSERT_HI:`SQ_ASSERT_LO];
      output_b_idle_auto_out         <= IDLE_RST[`IDLE_AUTO_BIT];
      output_b_mute_out              <=
        ~IDLE_RST[`IDLE_AUTO_BIT] & IDLE_RST[`IDLE_MUTE_BIT];
      output_b_signal_presence_detector_en_out <= IDLE_RST[`IDLE_AUTO_BIT];
      output_b_rate_auto_out         <= IDLE_RST[`RATE_AUTO_BIT];
      output_b_rate_fast_out         <=
        ~IDLE_RST[`RATE_AUTO_BIT] & IDLE_RST[`RATE_FAST_BIT];
      output_b_swing_code_out        <= BSWING_RST[6:0];
      output_b_swing_level_out       <= BSWING_DEC_RST[1:0];
      output_b_swing_bad_out         <= BSWING_DEC_RST[2];
    end else begin
      rx_boost_enable_out  <= boost_q[`BOOST_EN_BIT];
      gain_stage_field_out <=
        boost_q[`BOOST_STAGE_HI:`BOOST_STAGE_LO];
      boost_step_field_out <=
        boost_q[`BOOST_STEP_HI:`BOOST_STEP_LO];
      rx_boost_level_out    <= boost_level_d;
      rx_boost_code_bad_out <= (boost_level_d == 4'hf);
      output_a_swing_code_out  <= outa_swing_q[6:0];
      output_a_swing_level_out <= aswing_dec[1:0];
      output_a_swing_bad_out   <= aswing_dec[2];
      output_a_emphasis_enhanced_out <=
        outa_emph_q[`EMPH_TYPE_BIT];
      output_a_emphasis_level_out <= outa_emph_q[6:0];
      output_a_tx_emphasis_cut_out <= emph_cut_d;
      output_a_emphasis_bad_out    <= (emph_cut_d == 3'h7);
      squelch_deassert_sel_out <=
        squelch_q[`SQ_DEASSERT_HI:`SQ_DEASSERT_LO];
      squelch_assert_sel_out <=
        squelch_q[`SQ_ASSERT_HI:`SQ_ASSERT_LO];
      output_b_idle_auto_out <= idle_speed_q[`IDLE_AUTO_BIT];
      // manual mute only when automatic idle is off
      output_b_mute_out <= ~idle_speed_q[`IDLE_AUTO_BIT] &
        idle_speed_q[`IDLE_MUTE_BIT];
      // detector runs only in automatic mode
      output_b_signal_presence_detector_en_out <=
        idle_speed_q[`IDLE_AUTO_BIT];
      output_b_rate_auto_out <= idle_speed_q[`RATE_AUTO_BIT];
      output_b_rate_fast_out <= ~idle_speed_q[`RATE_AUTO_BIT] &
        idle_speed_q[`RATE_FAST_BIT];
      output_b_swing_code_out  <= outb_swing_q[6:0];
      output_b_swing_level_out <= bswing_dec[1:0];
      output_b_swing_bad_out   <= bswing_dec[2];
    end
  end

endmodule
`default_nettype wire

// >>> verification/lane0_regs_monitor.sv
// Purpose: port checker for lane0_conditioning_regs
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound by name after the module
`timescale 1ns/1ps
`default_nettype none
module lane0_regs_monitor (
  input wire logic       clk_sys_in, rst_in, reg_wr_in, reg_rd_in,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
  input wire logic       reg_rvalid_out, reg_addr_err_out,
  input wire logic       rx_boost_enable_out, output_a_swing_bad_out,
  input wire logic [1:0] gain_stage_field_out, output_a_swing_level_out,
  input wire logic [1:0] squelch_deassert_sel_out, squelch_assert_sel_out,
  input wire logic [2:0] boost_step_field_out,
  input wire logic [6:0] output_a_swing_code_out,
  input wire logic [6:0] output_a_emphasis_level_out,
  input wire logic       output_a_emphasis_enhanced_out, output_b_mute_out,
  input wire logic       output_b_idle_auto_out, output_b_rate_auto_out,
  input wire logic       output_b_rate_fast_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  read_pulse_a: assert property (
    reg_rvalid_out == $past(reg_rd_in)) else $error("read valid misplaced");
  addr_err_a: assert property (
    reg_addr_err_out == (($past(reg_rd_in) || $past(reg_wr_in)) &&
    !($past(reg_addr_in) inside {8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h32, 8'h34})))
    else $error("address error flag wrong");
  boost_fields_a: assert property (
    reg_rd_in && reg_addr_in == 8'h2c |=> reg_rdata_out == {2'b00,
    rx_boost_enable_out, gain_stage_field_out, boost_step_field_out})
    else $error("boost fields differ from register");
  squelch_fields_a: assert property (
    reg_rd_in && reg_addr_in == 8'h2f |=> reg_rdata_out == {4'h0,
    squelch_deassert_sel_out, squelch_assert_sel_out})
    else $error("squelch fields differ from register");
  emph_fields_a: assert property (
    reg_rd_in && reg_addr_in == 8'h2e |=> reg_rdata_out ==
    {output_a_emphasis_enhanced_out, output_a_emphasis_level_out})
    else $error("emphasis fields differ from register");
  idle_rate_a: assert property (
    reg_rd_in && reg_addr_in == 8'h32 |=> {output_b_idle_auto_out,
    output_b_mute_out, output_b_rate_auto_out, output_b_rate_fast_out} ==
    {reg_rdata_out[5], !reg_rdata_out[5] && reg_rdata_out[4],
    reg_rdata_out[1], !reg_rdata_out[1] && reg_rdata_out[0]})
    else $error("idle or rate decode wrong");
  swing_map_a: assert property (
    output_a_swing_bad_out ? output_a_swing_level_out == 2'd0 :
    int'(output_a_swing_level_out) == $countones(output_a_swing_code_out) - 2)
    else $error("swing level decode wrong");
  swing_follow_a: assert property (
    reg_wr_in && reg_addr_in == 8'h2d |=> ##1 {1'b0, output_a_swing_code_out}
    == ($past(reg_wdata_in, 2) & 8'h7f)) else $error("swing not updated");
  boost_write_c: cover property (reg_wr_in && reg_addr_in == 8'h2c);
  bad_access_c: cover property (reg_addr_err_out);
  mute_c: cover property (output_b_mute_out);
endmodule
bind lane0_conditioning_regs lane0_regs_monitor u_mon (.*);
`default_nettype wire

// >>> verification/smbus_host_model.sv
// Purpose: host that reads and writes the lane 0 bank
// Assumes: one-cycle strobes launched 2 ns after a rising edge
// Notes:   idle lines are inverted so stale values never help
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input  wire logic       clk_sys_in,
  output var  logic       wr_out, rd_out,
  output var  logic [7:0] addr_out, wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // reserved bits go out as zero unless a raw write is asked for
  function automatic logic [7:0] keep(input logic [7:0] a, d);
    case (a)
      8'h2c: keep = d & 8'h3f;
      8'h2d, 8'h34: keep = d & 8'h7f;
      8'h2f: keep = d & 8'h0f;
      8'h32: keep = d & 8'h33;
      default: keep = d;
    endcase
  endfunction
  task automatic put(input logic [7:0] a, d, input logic raw);
    @(posedge clk_sys_in);
    #2;
    addr_out = a;
    wdata_out = raw ? d : keep(a, d);
    wr_out = 1'b1;
    @(posedge clk_sys_in);
    #2;
    wr_out = 1'b0;
    addr_out = ~addr_out;
    wdata_out = ~wdata_out;
  endtask
  task automatic get(input logic [7:0] a);
    @(posedge clk_sys_in);
    #2;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_sys_in);
    #2;
    rd_out = 1'b0;
    addr_out = ~addr_out;
  endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: self-checking bench for lane0_conditioning_regs
// Assumes: host model drives the register port
// Notes:   random data from an lfsr seeded with 21
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  miscompares++; $display("CHECK FAILED t=%0t got %h want %h", $time, a, b); \
  end end
module testbench;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  wire logic reg_wr_in, reg_rd_in, reg_rvalid_out, reg_addr_err_out;
  wire logic rx_boost_enable_out, rx_boost_code_bad_out, output_b_mute_out;
  wire logic output_a_emphasis_enhanced_out, output_a_emphasis_bad_out;
  wire logic output_b_idle_auto_out, output_b_rate_auto_out;
  wire logic output_b_signal_presence_detector_en_out, output_b_rate_fast_out;
  wire logic output_a_swing_bad_out, output_b_swing_bad_out;
  wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire logic [6:0] output_a_swing_code_out, output_a_emphasis_level_out;
  wire logic [6:0] output_b_swing_code_out;
  wire logic [3:0] rx_boost_level_out;
  wire logic [2:0] boost_step_field_out, output_a_tx_emphasis_cut_out;
  wire logic [1:0] gain_stage_field_out, output_a_swing_level_out;
  wire logic [1:0] squelch_deassert_sel_out, squelch_assert_sel_out;
  wire logic [1:0] output_b_swing_level_out;
  int miscompares = 0;
  int samples_checked = 0;
  logic [7:0] lfsr_q = 8'h15;
  logic [7:0] mdl [256];
  logic [7:0] ma [6] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h32, 8'h34};
  logic [7:0] bt [9] = '{8'h20, 8'h2a, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37,
                         8'h3b, 8'h3d};
  logic [7:0] st [4] = '{8'h03, 8'h07, 8'h0f, 8'h1f};
  logic [7:0] et [5] = '{8'h01, 8'he8, 8'h88, 8'h90, 8'ha0};
  smbus_host_model u_host (.clk_sys_in(clk_sys_in), .wr_out(reg_wr_in),
    .rd_out(reg_rd_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
  lane0_conditioning_regs u_dut (.*);
  initial forever #20 clk_sys_in = ~clk_sys_in;
  function automatic logic [7:0] nxt(input logic [7:0] s);
    nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h2c: msk = 8'h3f;
      8'h2d, 8'h34: msk = 8'h7f;
      8'h2e: msk = 8'hff;
      8'h2f: msk = 8'h0f;
      8'h32: msk = 8'h33;
      default: msk = 8'h00;
    endcase
  endfunction
  function automatic logic [3:0] bidx(input logic [7:0] d);
    bidx = 4'hf;
    for (int k = 0; k < 9; k++) if (d == bt[k]) bidx = k[3:0];
  endfunction
  function automatic logic [3:0] ecut(input logic [7:0] d);
    ecut = 4'hf;
    for (int k = 0; k < 5; k++) if (d == et[k]) ecut = {1'b0, k[2:0]};
  endfunction
  function automatic logic [2:0] swl(input logic [7:0] d);
    swl = 3'b100;
    for (int k = 0; k < 4; k++) if (d == st[k]) swl = {1'b0, k[1:0]};
  endfunction
  task automatic rchk(input logic [7:0] a);
    logic hit;
    hit = msk(a) != 8'h00;
    u_host.get(a);
    `CHK(reg_rvalid_out, 1'b1)
    `CHK(reg_addr_err_out, !hit)
    `CHK(reg_rdata_out, hit ? mdl[a] : 8'h00)
  endtask
  task automatic dchk;
    logic [7:0] b, e, i;
    b = mdl[8'h2c];
    e = mdl[8'h2e];
    i = mdl[8'h32];
    `CHK({rx_boost_enable_out, gain_stage_field_out,
      boost_step_field_out}, b[5:0])
    `CHK(rx_boost_level_out, bidx(b))
    `CHK(rx_boost_code_bad_out, bidx(b) == 4'hf)
    `CHK({output_a_swing_bad_out, output_a_swing_level_out},
      swl(mdl[8'h2d]))
    `CHK({output_b_swing_bad_out, output_b_swing_level_out},
      swl(mdl[8'h34]))
    `CHK(output_a_swing_code_out, mdl[8'h2d][6:0])
    `CHK(output_b_swing_code_out, mdl[8'h34][6:0])
    `CHK({output_a_emphasis_enhanced_out, output_a_emphasis_level_out},
      e)
    `CHK({output_a_emphasis_bad_out, output_a_tx_emphasis_cut_out},
      ecut(e))
    `CHK({squelch_deassert_sel_out, squelch_assert_sel_out},
      mdl[8'h2f][3:0])
    `CHK({output_b_idle_auto_out, output_b_signal_presence_detector_en_out,
      output_b_mute_out},
      {i[5], i[5], !i[5] & i[4]})
    `CHK({output_b_rate_auto_out, output_b_rate_fast_out},
      {i[1], !i[1] & i[0]})
  endtask
  task automatic wchk(input logic [7:0] a, d, input logic raw);
    u_host.put(a, d, raw);
    mdl[a] = d & msk(a);
    @(posedge clk_sys_in);
    #2;
    rchk(a);
    dchk;
  endtask
  task automatic rst_mdl;
    foreach (mdl[k]) mdl[k] = 8'h00;
    mdl[8'h2c] = 8'h20;
    mdl[8'h2d] = 8'h03;
    mdl[8'h2e] = 8'h03;
    mdl[8'h34] = 8'h03;
  endtask
  task automatic final_report;
    $display("miscompares=%0d samples_checked=%0d", miscompares,
      samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    final_report;
  end
  initial begin
    logic [7:0] a;
    rst_mdl;
    repeat (12) @(posedge clk_sys_in);
    #2;
    rst_in = 1'b0;
    dchk;
    foreach (ma[k]) rchk(ma[k]);
    foreach (bt[k]) wchk(8'h2c, bt[k], 1'b0);
    foreach (st[k]) wchk(8'h2d, st[k], 1'b0);
    foreach (st[k]) wchk(8'h34, st[k], 1'b0);
    foreach (et[k]) wchk(8'h2e, et[k], 1'b0);
    for (int k = 0; k < 16; k++) wchk(8'h2f, k[7:0], 1'b0);
    for (int k = 0; k < 16; k++)
      wchk(8'h32, {2'b00, k[3:2], 2'b00, k[1:0]}, 1'b0);
    // deliberate host faults: reserved code, reserved bits, unmapped place
    wchk(8'h34, 8'h3f, 1'b1);
    wchk(8'h2c, 8'hff, 1'b1);
    wchk(8'h32, 8'hff, 1'b1);
    wchk(8'h30, 8'h55, 1'b1);
    for (int n = 0; n < 60; n++) begin
      lfsr_q = nxt(lfsr_q);
      a = ma[lfsr_q % 6];
      wchk(a, (a == 8'h2d || a == 8'h34) ? st[lfsr_q[7:6]] : nxt(lfsr_q),
        1'b0);
    end
    rst_in = 1'b1;
    rst_mdl;
    @(posedge clk_sys_in);
    #2;
    rst_in = 1'b0;
    dchk;
    rchk(8'h2c);
    final_report;
  end
endmodule
`default_nettype wire
